// [rtl/ncdp_pkg.sv]
package ncdp_pkg;
   // Opcodes handled by this datapath
   localparam logic [6:0] OP_CMPN = 7'h11;
   localparam logic [6:0] OP_DOT4 = 7'h54;
   localparam logic [6:0] OP_DPH = 7'h55;
   localparam logic [6:0] OP_DOT3 = 7'h56;
   localparam logic [6:0] OP_DOT2 = 7'h57;
   // Condition modifier encodings
   localparam logic [3:0] CM_NONE = 4'h0;
   localparam logic [3:0] CM_Z = 4'h1;
   localparam logic [3:0] CM_NOT_ZERO = 4'h2;
   localparam logic [3:0] CM_G = 4'h3;
   localparam logic [3:0] CM_GE = 4'h4;
   localparam logic [3:0] CM_L = 4'h5;
   localparam logic [3:0] CM_LE = 4'h6;
   localparam logic [3:0] CM_U = 4'h9;
   // Element type encodings
   localparam logic [2:0] TY_UB = 3'h0;
   localparam logic [2:0] TY_B = 3'h1;
   localparam logic [2:0] TY_UW = 3'h2;
   localparam logic [2:0] TY_W = 3'h3;
   localparam logic [2:0] TY_UD = 3'h4;
   localparam logic [2:0] TY_D = 3'h5;
   localparam logic [2:0] TY_F = 3'h6;
   // Register geometry and execution sizes
   localparam int REG_W = 256;
   localparam int NCHAN = 16;
   localparam logic [4:0] EXEC_TUPLE = 5'h04;
   localparam logic [4:0] EXEC_TWO_TUPLES = 5'h08;
   // Float constants
   localparam logic [31:0] FP_ONE = 32'h3F800000;
   localparam logic [31:0] FP_QNAN = 32'h7FC00000;
   localparam logic [31:0] FP_ZERO = 32'h00000000;
   localparam logic signed [9:0] FP_BIAS = 10'sh07F;
   localparam logic signed [9:0] FP_EXP_MAX = 10'sh0FF;
   localparam logic signed [9:0] FP_EXP_NONE = 10'sh200;
endpackage

// [rtl/ncdp_mac_if.sv]
`timescale 1ns/100ps
// One multiply-accumulate step: sum = acc + a * b
interface ncdp_mac_if;
   logic [31:0] a;
   logic [31:0] b;
   logic [31:0] acc;
   logic [31:0] sum;
   modport calc (input a, input b, input acc, output sum);
   modport user (output a, output b, output acc, input sum);
endinterface

// [rtl/ncdp_fmac.sv]
`timescale 1ns/100ps
// Single precision acc + a*b, truncating; denormals flush to zero
module ncdp_fmac import ncdp_pkg::*; (
   ncdp_mac_if.calc m
);
   logic [47:0] prod; // Full mantissa product
   logic any_special; // Any operand is inf or NaN
   logic ps; // Product sign
   logic signed [9:0] pe; // Product exponent
   logic [27:0] pm; // Product mantissa with guard bits
   logic signed [9:0] ce; // Accumulator exponent
   logic [27:0] cm; // Accumulator mantissa
   logic p_big; // Product has the larger magnitude
   logic bs, ss; // Signs of larger and smaller addend
   logic signed [9:0] be, se, re;
   logic [27:0] bm, sm, sum;
   logic [9:0] d; // Alignment distance

   // Combinational multiply, align, add and normalise
   always_comb begin
      prod = {1'b1, m.a[22:0]} * {1'b1, m.b[22:0]};
      any_special = (&m.a[30:23]) | (&m.b[30:23]) | (&m.acc[30:23]);
      ps = m.a[31] ^ m.b[31];
      pe = $signed({2'b00, m.a[30:23]}) + $signed({2'b00, m.b[30:23]}) - FP_BIAS;
      if (prod[47]) begin
         pe = pe + 10'sd1;
         pm = {1'b0, prod[47:24], 3'b000};
      end else begin
         pm = {1'b0, prod[46:23], 3'b000};
      end
      // Zero or denormal operands drop out of the sum
      if (m.a[30:23] == 8'h00 || m.b[30:23] == 8'h00) begin
         pe = FP_EXP_NONE;
         pm = 28'h0000000;
      end
      ce = $signed({2'b00, m.acc[30:23]});
      cm = {2'b01, m.acc[22:0], 3'b000};
      if (m.acc[30:23] == 8'h00) begin
         ce = FP_EXP_NONE;
         cm = 28'h0000000;
      end
      p_big = (pe > ce) || (pe == ce && pm >= cm);
      bs = p_big ? ps : m.acc[31];
      ss = p_big ? m.acc[31] : ps;
      be = p_big ? pe : ce;
      se = p_big ? ce : pe;
      bm = p_big ? pm : cm;
      sm = p_big ? cm : pm;
      d = 10'(be - se);
      sm = (d > 10'd27) ? 28'h0000000 : (sm >> d);
      sum = (bs == ss) ? bm + sm : bm - sm;
      re = be;
      // Carry out of the hidden bit moves the point one place
      if (sum[27]) begin
         sum = sum >> 1;
         re = re + 10'sd1;
      end
      // Cancellation: shift left until the hidden bit is back
      for (int i = 0; i < 27; i++) begin
         if (!sum[26] && sum != 28'h0000000) begin
            sum = sum << 1;
            re = re - 10'sd1;
         end
      end
      // Inf inputs collapse to NaN: a deliberate simplification
      if (any_special) begin
         m.sum = FP_QNAN;
      end else if (sum == 28'h0000000 || re <= 10'sd0) begin
         m.sum = FP_ZERO;
      end else if (re >= FP_EXP_MAX) begin
         m.sum = {bs, 8'hFF, 23'h000000};
      end else begin
         m.sum = {bs, re[7:0], sum[25:3]};
      end
   end
endmodule

// [rtl/ncdp_alu.sv]
`timescale 1ns/100ps
// Summary of operation
// RQ1: Compare subtracts src1 from src0, conditions include NaN
// RQ2: Flags packed per channel; dst channels replicate flag
// RQ3: Flag bit 0/1, dst element all zeros/ones
// RQ4: Issuer must give a nonzero condition modifier
// RQ5: NaN second source: true except not-zero
// RQ6: Pack 16 word or 8 dword results
// RQ7: Issuer never targets accumulator as compare destination
// RQ8: Issuer splits dword SIMD16 compare into two
// RQ9: Issuer sets thread switch for null destination
// RQ10: Four-wide dot sums four products, replicated
// RQ11: Three-wide dot drops fourth element, replicated
// RQ12: Two-wide dot uses first two elements only
// RQ13: Homogeneous dot is four-wide, replicated per tuple
// RQ14: Issuer uses execution size of four or more
// RQ15: Issuer uses horizontal stride one for dots
// RQ16: Issuer never sources the accumulator for dots
// RQ17: Homogeneous dot forces src0 fourth element to one
// RQ18: Disabled channels keep dst, flag bit zero
module ncdp_alu import ncdp_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic [6:0] i_opcode,
   input wire logic [3:0] i_cond,
   input wire logic [2:0] i_type,
   input wire logic [4:0] i_exec_size,
   input wire logic [15:0] i_chan_en,
   input wire logic i_dst_null,
   input wire logic i_flag_sel,
   input wire logic [255:0] i_src0,
   input wire logic [255:0] i_src1,
   input wire logic [255:0] i_dst_old,
   output logic o_ready,
   output logic o_done,
   output logic o_illegal,
   output logic [255:0] o_dst,
   output logic o_dst_we,
   output logic [15:0] o_flag,
   output logic o_flag_we,
   output logic o_flag_sel
);
   typedef enum logic [0:0] {ST_IDLE, ST_DOT} ncdp_state_t;

   // Element of a register, sign or zero extended to 33 bits
   function automatic logic [32:0] elem(input logic [255:0] r, input int idx, input logic [2:0] ty);
      case (ty)
         TY_UB: elem = {25'h0000000, r[idx * 8 +: 8]};
         TY_B: elem = {{25{r[idx * 8 + 7]}}, r[idx * 8 +: 8]};
         TY_UW: elem = {17'h00000, r[idx * 16 +: 16]};
         TY_W: elem = {{17{r[idx * 16 + 15]}}, r[idx * 16 +: 16]};
         TY_UD: elem = {1'b0, r[(idx % 8) * 32 +: 32]};
         default: elem = {r[(idx % 8) * 32 + 31], r[(idx % 8) * 32 +: 32]};
      endcase
   endfunction

   // Monotonic key for float ordering; both zeros map alike
   function automatic logic [31:0] fkey(input logic [31:0] x);
      if (x[30:0] == 31'h00000000) begin
         fkey = 32'h80000000;
      end else begin
         fkey = x[31] ? ~x : {1'b1, x[30:0]};
      end
   endfunction

   // Condition evaluation with the NaN source signal folded in
   function automatic logic cond_hit(input logic [3:0] cm, input logic lt, input logic eq,
                                     input logic nan_a, input logic nan_b);
      if (nan_b) begin
         cond_hit = (cm != CM_NOT_ZERO); // RQ5
      end else if (nan_a) begin
         cond_hit = (cm == CM_NOT_ZERO) || (cm == CM_U); // RQ1
      end else begin
         case (cm)
            CM_Z: cond_hit = eq;
            CM_NOT_ZERO: cond_hit = !eq;
            CM_G: cond_hit = !lt && !eq;
            CM_GE: cond_hit = !lt;
            CM_L: cond_hit = lt;
            CM_LE: cond_hit = lt || eq;
            default: cond_hit = 1'b0;
         endcase
      end
   endfunction

   ncdp_state_t state; // Sequencer state
   logic [255:0] s0, s1; // Dot sources held for the whole sequence
   logic [6:0] op; // Dot opcode held
   logic [7:0] cen; // Dot channel enables held
   logic tup; // Current tuple
   logic last_tup; // Final tuple index
   logic [1:0] el; // Current element inside the tuple
   logic [31:0] acc; // Running partial sum

   ncdp_mac_if mac ();

   ncdp_fmac u_fmac (
      .m(mac.calc)
   );

   // Decode of the request
   wire is_cmp = (i_opcode == OP_CMPN);
   wire is_dot = (i_opcode == OP_DOT4) || (i_opcode == OP_DPH) || (i_opcode == OP_DOT3) || (i_opcode == OP_DOT2);
   wire is_dw = (i_type == TY_UD) || (i_type == TY_D) || (i_type == TY_F);
   // A zero modifier has no meaning, so it is refused rather than guessed
   wire cmp_bad = (i_cond == CM_NONE); // RQ4
   // Only one register of floats is held, so at most two tuples
   wire dot_bad = (i_exec_size < EXEC_TUPLE) || (i_exec_size > EXEC_TWO_TUPLES); // RQ14

   // Channels live for this compare
   logic [15:0] exec_mask;
   logic [15:0] ch_en;
   logic [15:0] cmp_bit;
   logic [127:0] byte_v; // Byte lanes reach only the low half
   logic [255:0] word_v, dw_v;
   always_comb begin
      for (int k = 0; k < NCHAN; k++) begin
         exec_mask[k] = (5'(k) < i_exec_size);
      end
   end
   assign ch_en = i_chan_en & exec_mask & (is_dw ? 16'h00FF : 16'hFFFF); // RQ6 RQ8

   // Per-channel compare and destination element forming
   for (genvar g = 0; g < NCHAN; g++) begin : g_ch
      wire [32:0] ea = elem(i_src0, g, i_type);
      wire [32:0] eb = elem(i_src1, g, i_type);
      wire is_f = (i_type == TY_F);
      wire nan_a = is_f && (&ea[30:23]) && (ea[22:0] != 23'h000000);
      wire nan_b = is_f && (&eb[30:23]) && (eb[22:0] != 23'h000000);
      // Integer difference with one spare bit, so no overflow
      wire [33:0] diff = {ea[32], ea} - {eb[32], eb}; // RQ1
      wire [31:0] ka = fkey(ea[31:0]);
      wire [31:0] kb = fkey(eb[31:0]);
      wire lt = is_f ? (ka < kb) : diff[33];
      wire eq = is_f ? (ka == kb) : (diff == 34'h000000000);
      assign cmp_bit[g] = ch_en[g] && cond_hit(i_cond, lt, eq, nan_a, nan_b); // RQ3 RQ18
      assign byte_v[g * 8 +: 8] = ch_en[g] ? {8{cmp_bit[g]}} : i_dst_old[g * 8 +: 8]; // RQ3
      assign word_v[g * 16 +: 16] = ch_en[g] ? {16{cmp_bit[g]}} : i_dst_old[g * 16 +: 16]; // RQ3
      if (g < 8) begin : g_dw
         assign dw_v[g * 32 +: 32] = ch_en[g] ? {32{cmp_bit[g]}} : i_dst_old[g * 32 +: 32]; // RQ2 RQ18
      end
   end

   // Destination layout follows element width
   wire byte_ty = (i_type == TY_UB) || (i_type == TY_B);
   wire [255:0] cmp_dst = byte_ty ? {128'h0, byte_v[127:0]} | (i_dst_old & {128'hFFFFFFFF_FFFFFFFF_FFFFFFFF_FFFFFFFF,
                          128'h0}) : (is_dw ? dw_v : word_v);

   // Multiply-accumulate operands; homogeneous dot uses one for src0 w
   wire [7:0] bit_ofs = {tup, el, 5'b00000};
   assign mac.a = (op == OP_DPH && el == 2'd3) ? FP_ONE : s0[bit_ofs +: 32]; // RQ17
   assign mac.b = s1[bit_ofs +: 32]; // RQ15
   assign mac.acc = acc;
   // Last element taken into the sum for each dot variant
   wire [1:0] last_el = (op == OP_DOT2) ? 2'd1 : ((op == OP_DOT3) ? 2'd2 : 2'd3); // RQ10 RQ11 RQ12 RQ13

   assign o_ready = (state == ST_IDLE);

   // Request acceptance and compare writeback
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= ST_IDLE;
         o_done <= 1'b0;
         o_illegal <= 1'b0;
         o_dst_we <= 1'b0;
         o_flag <= 16'h0000;
         o_flag_we <= 1'b0;
         o_flag_sel <= 1'b0;
      end else begin
         o_done <= 1'b0;
         o_dst_we <= 1'b0;
         o_flag_we <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (i_start && is_cmp && !cmp_bad) begin
                  // Null destination only updates the flag register
                  o_dst_we <= !i_dst_null; // RQ2 RQ9
                  o_flag <= cmp_bit; // RQ2 RQ6
                  o_flag_we <= 1'b1;
                  o_flag_sel <= i_flag_sel;
                  o_done <= 1'b1;
                  o_illegal <= 1'b0;
               end else if (i_start && is_dot && !dot_bad) begin
                  state <= ST_DOT;
                  o_illegal <= 1'b0;
               end else if (i_start) begin
                  // Unknown or malformed: finish at once, write nothing
                  o_done <= 1'b1;
                  o_illegal <= 1'b1;
               end
            end
            ST_DOT: begin
               if (el == last_el && tup == last_tup) begin
                  state <= ST_IDLE;
                  o_done <= 1'b1;
                  o_dst_we <= 1'b1;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Destination data and dot sequencing
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_dst <= 256'h0;
         s0 <= 256'h0;
         s1 <= 256'h0;
         op <= OP_DOT4;
         cen <= 8'h00;
         tup <= 1'b0;
         last_tup <= 1'b0;
         el <= 2'd0;
         acc <= FP_ZERO;
      end else if (state == ST_IDLE) begin
         if (i_start && is_cmp) begin
            o_dst <= cmp_dst;
         end else if (i_start && is_dot) begin
            // Sources held so the issuer may move on
            o_dst <= i_dst_old;
            s0 <= i_src0;
            s1 <= i_src1;
            op <= i_opcode;
            cen <= i_chan_en[7:0] & exec_mask[7:0];
            last_tup <= (i_exec_size == EXEC_TWO_TUPLES);
            tup <= 1'b0;
            el <= 2'd0;
            acc <= FP_ZERO;
         end
      end else if (el == last_el) begin
         // Scalar replicated to the enabled lanes of the tuple
         for (int k = 0; k < 4; k++) begin
            if (cen[{tup, 2'(k)}]) begin
               o_dst[{tup, 2'(k), 5'b00000} +: 32] <= mac.sum; // RQ10 RQ13
            end
         end
         acc <= FP_ZERO;
         el <= 2'd0;
         tup <= !tup;
      end else begin
         acc <= mac.sum;
         el <= el + 2'd1;
      end
   end
endmodule

// [testbench/ncdp_rf_model.sv]
`timescale 1ns/100ps
// Register file side: holds the destination register image
module ncdp_rf_model (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic [255:0] i_load_val,
   input wire logic [255:0] i_dst,
   input wire logic i_dst_we,
   output logic [255:0] o_dst_old
);
   // Preload wins over a write; the bench never asks for both at once
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_dst_old <= 256'h0;
      end else if (i_load) begin
         o_dst_old <= i_load_val;
      end else if (i_dst_we) begin
         o_dst_old <= i_dst;
      end
   end
endmodule

// [testbench/ncdp_alu_chk.sv]
`timescale 1ns/100ps
// Port checks for the compare and dot datapath
module ncdp_alu_chk import ncdp_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic [6:0] i_opcode,
   input wire logic [3:0] i_cond,
   input wire logic [2:0] i_type,
   input wire logic [4:0] i_exec_size,
   input wire logic [15:0] i_chan_en,
   input wire logic i_dst_null,
   input wire logic i_flag_sel,
   input wire logic [255:0] i_src0,
   input wire logic [255:0] i_src1,
   input wire logic [255:0] i_dst_old,
   input wire logic o_ready,
   input wire logic o_done,
   input wire logic o_illegal,
   input wire logic [255:0] o_dst,
   input wire logic o_dst_we,
   input wire logic [15:0] o_flag,
   input wire logic o_flag_we,
   input wire logic o_flag_sel
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic take, cmp_ok, cm_zero, dot_done;
   logic [3:0] en_lo; // Enables of tuple zero
   assign take = i_start && o_ready;
   assign cmp_ok = take && i_opcode == OP_CMPN && i_cond != CM_NONE;
   assign cm_zero = take && i_opcode == OP_CMPN && i_cond == CM_NONE;
   assign dot_done = o_dst_we && !o_flag_we; // Only dots write without flags
   // Held from acceptance; no reset needed as checks are off in reset
   always_ff @(posedge i_core_clk) begin
      if (take) begin
         en_lo <= i_chan_en[3:0];
      end
   end
   cmp_ans_a: assert property (cmp_ok |=> o_done && o_flag_we && !o_illegal)
      else $error("compare answer missing");
   zero_cm_a: assert property (cm_zero |=> o_done && o_illegal && !o_flag_we && !o_dst_we)
      else $error("zero modifier accepted");
   null_dst_a: assert property (cmp_ok && i_dst_null |=> !o_dst_we)
      else $error("null destination written");
   off_flag_a: assert property (o_flag_we |-> (o_flag & ~$past(i_chan_en)) == 16'h0000)
      else $error("disabled channel flag set");
   flag_sel_a: assert property (cmp_ok |=> o_flag_sel == $past(i_flag_sel))
      else $error("flag register select lost");
   dot2_time_a: assert property (take && i_opcode == OP_DOT2 && i_exec_size == EXEC_TUPLE
      |=> !o_done[*2] ##1 o_done && o_dst_we && !o_flag_we) else $error("two-wide timing");
   dot4_time_a: assert property (take && i_opcode == OP_DOT4 && i_exec_size == EXEC_TWO_TUPLES
      |=> !o_done[*8] ##1 o_done && o_dst_we && !o_flag_we) else $error("four-wide timing");
   dot_rep_a: assert property (dot_done && en_lo == 4'hF
      |-> o_dst[63:32] == o_dst[31:0] && o_dst[127:64] == o_dst[63:0]) else $error("dot not replicated");
endmodule
bind ncdp_alu ncdp_alu_chk u_ncdp_alu_chk (.*);

// [testbench/ncdp_alu_tb.sv]
`timescale 1ns/100ps
// Self-checking bench; the register file model feeds back the destination image
module ncdp_alu_tb import ncdp_pkg::*;;
   logic i_core_clk = 1'b0, i_rst = 1'b1, i_start = 1'b0, i_dst_null = 1'b0, i_flag_sel = 1'b0, ld = 1'b0;
   logic [6:0] i_opcode = 7'h00;
   logic [3:0] i_cond = 4'h0;
   logic [2:0] i_type = 3'h0;
   logic [4:0] i_exec_size = 5'h00;
   logic [15:0] i_chan_en = 16'h0000, o_flag, r_flag;
   logic [255:0] i_src0 = 256'h0, i_src1 = 256'h0, ld_val = 256'h0, dst_old, o_dst, r_dst;
   logic o_ready, o_done, o_illegal, o_dst_we, o_flag_we, o_flag_sel, r_dwe, r_fwe, r_ill;
   int fails = 0;
   int tests_run = 0;
   ncdp_alu u_ncdp_alu (.i_core_clk, .i_rst, .i_start, .i_opcode, .i_cond, .i_type, .i_exec_size, .i_chan_en,
      .i_dst_null, .i_flag_sel, .i_src0, .i_src1, .i_dst_old(dst_old), .o_ready, .o_done, .o_illegal, .o_dst,
      .o_dst_we, .o_flag, .o_flag_we, .o_flag_sel);
   ncdp_rf_model u_ncdp_rf_model (.i_core_clk, .i_rst, .i_load(ld), .i_load_val(ld_val), .i_dst(o_dst),
      .i_dst_we(o_dst_we), .o_dst_old(dst_old));
   initial forever #25 i_core_clk = ~i_core_clk;
   task automatic cmp_val(input logic [255:0] got, input logic [255:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic load(input logic [255:0] v);
      ld_val = v;
      ld = 1'b1;
      @(negedge i_core_clk);
      ld = 1'b0;
   endtask
   // One request; bounded wait for the answer, then one idle edge
   task automatic issue(input logic [6:0] op, input logic [3:0] cm, input logic [2:0] ty, input logic [4:0] ex,
      input logic [15:0] en, input logic [255:0] s0, input logic [255:0] s1);
      int k;
      {i_opcode, i_cond, i_type, i_exec_size, i_chan_en, i_src0, i_src1} = {op, cm, ty, ex, en, s0, s1};
      i_start = 1'b1;
      @(negedge i_core_clk);
      i_start = 1'b0;
      for (k = 0; k < 20 && o_done !== 1'b1; k++) @(negedge i_core_clk);
      fails += (k == 20);
      if (k == 20) finish_test();
      {r_dst, r_flag, r_dwe, r_fwe, r_ill} = {o_dst, o_flag, o_dst_we, o_flag_we, o_illegal};
      @(negedge i_core_clk);
   endtask
   // Word greater-than; channels 8..11 are off right past the threshold
   task automatic sc_word();
      logic [255:0] s0;
      for (int n = 0; n < 16; n++) s0[16*n +: 16] = 16'(n);
      i_flag_sel = 1'b1;
      load({16{16'h5A3C}});
      issue(OP_CMPN, CM_G, TY_UW, 5'h10, 16'hF0FF, s0, {16{16'h0008}});
      cmp_val(r_flag, 16'hF000);
      cmp_val(o_flag_sel, 1'b1);
      cmp_val(r_dst, {{4{16'hFFFF}}, {4{16'h5A3C}}, {8{16'h0000}}});
      i_flag_sel = 1'b0;
   endtask
   // NaN second source, every modifier
   task automatic sc_nan();
      logic [3:0] cm [7] = '{CM_Z, CM_NOT_ZERO, CM_G, CM_GE, CM_L, CM_LE, CM_U};
      load(256'h0);
      for (int k = 0; k < 7; k++) begin
         issue(OP_CMPN, cm[k], TY_F, EXEC_TWO_TUPLES, 16'hFFFF, {8{FP_ONE}}, {8{FP_QNAN}});
         cmp_val(r_flag, {8'h00, {8{cm[k] != CM_NOT_ZERO}}});
         cmp_val(r_dst, {256{cm[k] != CM_NOT_ZERO}});
      end
   endtask
   // Unordered test on a NaN first source with half the lanes off, signed less-than, a short dot
   task automatic sc_mixed();
      logic [255:0] s0;
      for (int n = 0; n < 8; n++) s0[32*n +: 32] = 32'(n - 4);
      load(256'h0);
      issue(OP_CMPN, CM_U, TY_F, EXEC_TWO_TUPLES, 16'h00F0, {8{FP_QNAN}}, {8{FP_ONE}});
      cmp_val(r_flag, 16'h00F0);
      cmp_val(r_dst, {{4{32'hFFFFFFFF}}, 128'h0});
      issue(OP_CMPN, CM_L, TY_D, EXEC_TWO_TUPLES, 16'hFFFF, s0, 256'h0);
      cmp_val(r_flag, 16'h000F);
      cmp_val(r_dst, {128'h0, {4{32'hFFFFFFFF}}});
      issue(OP_DOT4, CM_NONE, TY_F, 5'h02, 16'hFFFF, s0, s0);
      cmp_val({r_ill, r_dwe, r_fwe}, 3'h4);
   endtask
   // Byte equality, then to the null register, then a refused request
   task automatic sc_byte();
      logic [255:0] s0, s1;
      for (int n = 0; n < 32; n++) begin
         s0[8*n +: 8] = 8'(n);
         s1[8*n +: 8] = 8'(n + n % 2);
      end
      load({32{8'hC3}});
      issue(OP_CMPN, CM_Z, TY_UB, 5'h10, 16'hFFFF, s0, s1);
      cmp_val(r_dst, {{16{8'hC3}}, {8{16'h00FF}}});
      i_dst_null = 1'b1;
      issue(OP_CMPN, CM_Z, TY_UB, 5'h10, 16'hFFFF, s0, s1);
      i_dst_null = 1'b0;
      cmp_val({r_flag, r_dwe, r_fwe}, {16'h5555, 2'h1});
      issue(OP_CMPN, CM_NONE, TY_UW, 5'h10, 16'hFFFF, s0, s1);
      cmp_val({r_ill, r_dwe, r_fwe}, 3'h4);
      cmp_val(dst_old, {{16{8'hC3}}, {8{16'h00FF}}});
   endtask
   // Dot forms on tuples 1,2,3,4 against 2.0; homogeneous runs with lane 7 off
   task automatic sc_dots();
      logic [6:0] op [4] = '{OP_DOT2, OP_DOT3, OP_DOT4, OP_DPH};
      logic [31:0] res [4] = '{32'h40C00000, 32'h41400000, 32'h41A00000, 32'h41600000};
      logic [255:0] exp;
      for (int k = 0; k < 4; k++) begin
         exp = {8{32'h0F1E2D3C}};
         load(exp);
         for (int n = 0; n < (k == 0 ? 4 : 8); n++) exp[32*n +: 32] = (k == 3 && n == 7) ? exp[255:224] : res[k];
         issue(op[k], CM_NONE, TY_F, k == 0 ? EXEC_TUPLE : EXEC_TWO_TUPLES, k == 3 ? 16'hFF7F : 16'hFFFF,
            {2{32'h40800000, 32'h40400000, 32'h40000000, FP_ONE}}, {8{32'h40000000}});
         cmp_val(r_dst, exp);
         cmp_val({r_dwe, r_fwe}, 2'h2);
      end
   endtask
   initial begin
      repeat (8) @(negedge i_core_clk);
      i_rst = 1'b0;
      cmp_val({o_ready, o_done, o_dst_we, o_flag_we, o_dst}, {4'h8, 256'h0});
      @(negedge i_core_clk);
      sc_word();
      sc_nan();
      sc_mixed();
      sc_byte();
      sc_dots();
      finish_test();
   end
endmodule
